/* logic/sppc_port_ctl.sv */
`include "sppc_cfg.svh"
module sppc_port_ctl (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic reference_clock_in,
   input wire logic tx_phase_align_reset_n,
   input wire logic [`SPPC_CHANNELS-1:0] tx_input_clock_ch,
   output logic txAlignBusy,
   input wire logic [`SPPC_CHANNELS-1:0][`SPPC_CHAR_W-1:0] deserChar,
   input wire logic [`SPPC_CHANNELS-1:0] deserValid,
   output logic [`SPPC_CHANNELS-1:0] deserReady,
   output logic rx_interface_clock,
   output logic [`SPPC_CHANNELS-1:0][`SPPC_CHAR_W-1:0] rx_char_out,
   output logic [`SPPC_CHANNELS-1:0] framing_char_flag,
   output logic [`SPPC_CHANNELS-1:0] rx_odd_parity_out,
   output logic [`SPPC_CHANNELS-1:0] rxOddParityOe
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   localparam int CH = `SPPC_CHANNELS;

   // pin synchronisers; stage one feeds stage two only
   logic refS1, refS2, refS3, rstS1, rstS2;
   logic [CH-1:0] txS1, txS2, txS3;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         refS1 <= 1'b0;
         refS2 <= 1'b0;
         refS3 <= 1'b0;
         rstS1 <= 1'b1;
         rstS2 <= 1'b1;
         txS1 <= '0;
         txS2 <= '0;
         txS3 <= '0;
      end else begin
         refS1 <= reference_clock_in;
         refS2 <= refS1;
         refS3 <= refS2;
         rstS1 <= tx_phase_align_reset_n;
         rstS2 <= rstS1;
         txS1 <= tx_input_clock_ch;
         txS2 <= txS1;
         txS3 <= txS2;
      end
   end

   logic refRise, refFall;
   logic [CH-1:0] txRise;
   assign refRise = refS2 && !refS3;
   assign refFall = !refS2 && refS3;
   assign txRise = txS2 & ~txS3;

   // software register file
   logic [`SPPC_CTRL_W-1:0] ctrlQ, ctrlD;
   logic ackQ, ackD;
   logic [31:0] datQ, datD;
   logic [31:0] statusWord, phaseWord;
   logic wbWrite;

   sppc_pkg::sppc_level_t parityCtl, txSel, frameSel;
   logic halfSel, halfRate, bypass, invalidMode;
   logic [4:0] pllMult;

   assign parityCtl = ctrlQ[`SPPC_F_PARITY +: 2];
   assign txSel = ctrlQ[`SPPC_F_TXSEL +: 2];
   assign halfSel = ctrlQ[`SPPC_F_HALFRATE];
   assign frameSel = ctrlQ[`SPPC_F_FRAMESEL +: 2];
   assign halfRate = (txSel == `SPPC_LVL_LOW) && halfSel;
   assign bypass = (txSel == `SPPC_LVL_LOW) && !halfSel;
   // half-rate with txSel not low is not a usable mode; flagged, though pllMult still takes the half-rate value
   assign invalidMode = (txSel != `SPPC_LVL_LOW) && halfSel;
   assign pllMult = halfSel ? `SPPC_PLL_MULT_HALF : `SPPC_PLL_MULT_FULL;

   // write lands on the edge where the master sees ack
   assign wbWrite = wb_cyc_i && wb_stb_i && ackQ && wb_we_i;

   always_comb begin
      ackD = wb_cyc_i && wb_stb_i && !ackQ;
      datD = datQ;
      ctrlD = ctrlQ;
      if (ackD) begin
         case (wb_adr_i)
            `SPPC_REG_CTRL: begin
               datD = {{(32 - `SPPC_CTRL_W){1'b0}}, ctrlQ};
            end
            `SPPC_REG_STATUS: begin
               datD = statusWord;
            end
            `SPPC_REG_PHASE: begin
               datD = phaseWord;
            end
            default: begin
               datD = 32'h0000_0000;
            end
         endcase
      end
      if (wbWrite && wb_adr_i == `SPPC_REG_CTRL && wb_sel_i[0]) begin
         ctrlD = wb_dat_i[`SPPC_CTRL_W-1:0];
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ackQ <= 1'b0;
         datQ <= 32'h0000_0000;
         ctrlQ <= `SPPC_CTRL_RESET;
      end else begin
         ackQ <= ackD;
         datQ <= datD;
         ctrlQ <= ctrlD;
      end
   end

   assign wb_ack_o = ackQ;
   assign wb_dat_o = datQ;

   // phase-align reset sequencing
   sppc_pkg::sppc_pa_state_e paStateQ, paStateD;
   logic [1:0] lowCntQ, lowCntD;
   logic sampleEdge, startAdjust;

   assign sampleEdge = refRise || (halfRate && refFall);
   // two consecutive low samples are needed before anything moves
   assign startAdjust = sampleEdge && !rstS2 && (lowCntQ >= (`SPPC_MIN_LOW_EDGES - 2'h1));

   always_comb begin
      lowCntD = lowCntQ;
      if (sampleEdge) begin
         lowCntD = rstS2 ? 2'h0 : ((lowCntQ == 2'h3) ? 2'h3 : lowCntQ + 2'h1);
      end
      paStateD = paStateQ;
      case (paStateQ)
         sppc_pkg::PA_WAIT, sppc_pkg::PA_LOCKED: begin
            if (startAdjust) begin
               paStateD = sppc_pkg::PA_ADJUST;
            end
         end
         sppc_pkg::PA_ADJUST: begin
            if (sampleEdge && rstS2) begin
               paStateD = sppc_pkg::PA_LOCKED;
            end
         end
         default: begin
            paStateD = sppc_pkg::PA_WAIT;
         end
      endcase
      if (bypass) begin
         paStateD = sppc_pkg::PA_BYPASS;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         paStateQ <= sppc_pkg::PA_WAIT;
         lowCntQ <= 2'h0;
      end else begin
         paStateQ <= paStateD;
         lowCntQ <= lowCntD;
      end
   end

   // downstream must tolerate slips while this is high
   assign txAlignBusy = (paStateQ == sppc_pkg::PA_ADJUST);

   // reference duty measurement for half-rate buffer faults
   logic [3:0] levelCntQ, levelCntD, hiLenQ, hiLenD, sinceRefQ, sinceRefD, asymDiff;
   logic faultQ, faultD, faultSet;

   always_comb begin
      levelCntD = (refRise || refFall) ? 4'h0 : ((levelCntQ == 4'hf) ? 4'hf : levelCntQ + 4'h1);
      sinceRefD = refRise ? 4'h0 : ((sinceRefQ == 4'hf) ? 4'hf : sinceRefQ + 4'h1);
      hiLenD = refFall ? levelCntQ : hiLenQ;
      asymDiff = (hiLenQ > levelCntQ) ? hiLenQ - levelCntQ : levelCntQ - hiLenQ;
      faultSet = halfRate && refRise && (asymDiff > `SPPC_ASYM_MAX_CYC);
      // a fault seen during the clearing window still sticks
      faultD = faultSet || (faultQ && !(halfRate && paStateQ == sppc_pkg::PA_ADJUST));
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         levelCntQ <= 4'h0;
         sinceRefQ <= 4'h0;
         hiLenQ <= 4'h0;
         faultQ <= 1'b0;
      end else begin
         levelCntQ <= levelCntD;
         sinceRefQ <= sinceRefD;
         hiLenQ <= hiLenD;
         faultQ <= faultD;
      end
   end

   // receive interface clock, made here by division
   logic [2:0] rxDivQ, rxDivD;
   logic rxClkQ, rxClkD, rxClkPrevQ, popStrobe;

   always_comb begin
      rxDivD = rxDivQ + 3'h1;
      rxClkD = rxClkQ;
      if (rxDivQ == 3'(`SPPC_RXCLK_HALF_CYC - 1)) begin
         rxDivD = 3'h0;
         rxClkD = !rxClkQ;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rxDivQ <= 3'h0;
         rxClkQ <= 1'b0;
         rxClkPrevQ <= 1'b0;
      end else begin
         rxDivQ <= rxDivD;
         rxClkQ <= rxClkD;
         rxClkPrevQ <= rxClkQ;
      end
   end

   assign rx_interface_clock = rxClkQ;
   assign popStrobe = rxClkQ && !rxClkPrevQ;

   logic [CH-1:0][`SPPC_PHASE_W-1:0] phaseBus;
   logic [CH-1:0] fifoValid, fifoFull;

   for (genvar ch = 0; ch < CH; ch++) begin : g_ch
      logic [`SPPC_PHASE_W-1:0] phaseQ, phaseD;
      sppc_pkg::sppc_char_t fifoData;

      always_comb begin
         phaseD = phaseQ;
         if (paStateQ == sppc_pkg::PA_ADJUST && !halfRate && txRise[ch]) begin
            phaseD = sinceRefQ;
         end
      end

      always_ff @(posedge ref_clk or negedge reset_n) begin
         if (!reset_n) begin
            phaseQ <= '0;
         end else begin
            phaseQ <= phaseD;
         end
      end

      assign phaseBus[ch] = phaseQ;
      assign fifoFull[ch] = !deserReady[ch];

      sppc_fifo #(.WIDTH(`SPPC_CHAR_W), .DEPTH(`SPPC_FIFO_DEPTH)) u_fifo (
         .ref_clk(ref_clk),
         .reset_n(reset_n),
         .inValid(deserValid[ch]),
         .inReady(deserReady[ch]),
         .inData(deserChar[ch]),
         .outValid(fifoValid[ch]),
         .outReady(popStrobe),
         .outData(fifoData)
      );

      sppc_rx_lane u_lane (
         .ref_clk(ref_clk),
         .reset_n(reset_n),
         .load(popStrobe && fifoValid[ch]),
         .inChar(fifoData),
         .frameSel(frameSel),
         .parityCtl(parityCtl),
         .rxChar(rx_char_out[ch]),
         .frameFlag(framing_char_flag[ch]),
         .parityBit(rx_odd_parity_out[ch]),
         .parityOe(rxOddParityOe[ch])
      );
   end

   assign phaseWord = {{(32 - CH * `SPPC_PHASE_W){1'b0}}, phaseBus};
   assign statusWord = {14'h0000, fifoFull, fifoValid, pllMult, faultQ, invalidMode,
      (paStateQ == sppc_pkg::PA_BYPASS), (paStateQ == sppc_pkg::PA_LOCKED), txAlignBusy};

   bypass_ignore_a: assert property ((bypass && $past(bypass)) |-> paStateQ == sppc_pkg::PA_BYPASS)
      else $error("phase-align reset acted while bypassed");
   adjust_entry_a: assert property ((startAdjust && !bypass) |=> txAlignBusy)
      else $error("second low sample did not start realignment");
   single_low_a: assert property ((sampleEdge && !rstS2 && lowCntQ == 2'h0 && !txAlignBusy) |=> !txAlignBusy)
      else $error("realignment began on a single low sample");
   lock_hold_a: assert property ((paStateQ != sppc_pkg::PA_ADJUST && $past(paStateQ) != sppc_pkg::PA_ADJUST) |-> $stable(phaseWord))
      else $error("captured phase moved outside realignment");
   half_fault_a: assert property ((halfRate && txAlignBusy && !faultSet) |=> !faultQ ##1 (!faultQ || $past(faultSet)))
      else $error("half-rate reset did not clear the fault");
   busy_rise_a: assert property ($rose(txAlignBusy) |-> $past(sampleEdge) && !$past(rstS2))
      else $error("realignment started without a low sample");
   rx_update_a: assert property (!$stable(rx_char_out) |-> $past(popStrobe) && rx_interface_clock)
      else $error("receive character changed away from interface clock rise");
   pll_mult_a: assert property ((wb_ack_o && $past(wb_adr_i) == `SPPC_REG_STATUS && $past(halfSel)) |-> wb_dat_o[9:5] == 5'h14)
      else $error("status shows wrong multiplier for half rate");
   half_edge_a: assert property ((halfRate && refFall && !rstS2 && !bypass) |=> lowCntQ != 2'h0)
      else $error("falling reference edge not sampled in half-rate mode");
   wb_ack_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
      else $error("wishbone ack not a single cycle after request");

   realign_lock_c: cover property (txAlignBusy ##[1:200] paStateQ == sppc_pkg::PA_LOCKED);
   half_clear_c: cover property (faultQ && halfRate ##[1:200] !faultQ);
   fifo_drain_c: cover property (fifoFull[0] ##[1:100] !fifoValid[0]);
endmodule

/* logic/sppc_cfg.svh */
`ifndef SPPC_CFG_SVH
`define SPPC_CFG_SVH

`define SPPC_CHANNELS 4
`define SPPC_CHAR_W 10
`define SPPC_FIFO_DEPTH 8
`define SPPC_PHASE_W 4

// register byte offsets
`define SPPC_REG_CTRL 4'h0
`define SPPC_REG_STATUS 4'h4
`define SPPC_REG_PHASE 4'h8

// control register layout
`define SPPC_CTRL_W 7
`define SPPC_F_PARITY 0
`define SPPC_F_TXSEL 2
`define SPPC_F_HALFRATE 4
`define SPPC_F_FRAMESEL 5
`define SPPC_CTRL_RESET 7'h25

// three-level select encodings
`define SPPC_LVL_LOW 2'h0
`define SPPC_LVL_MID 2'h1
`define SPPC_LVL_HIGH 2'h2

`define SPPC_MIN_LOW_EDGES 2'h2
`define SPPC_PLL_MULT_HALF 5'h14
`define SPPC_PLL_MULT_FULL 5'h0a
`define SPPC_ASYM_MAX_CYC 4'h2

// framing patterns, bit 9 first on the line
`define SPPC_K285_NEG 10'h0fa
`define SPPC_K285_POS 10'h305
`define SPPC_COMMA_NEG 7'h1f
`define SPPC_COMMA_POS 7'h60

// timing
`define SPPC_CLK_PERIOD_NS 50
`define SPPC_RXCLK_HALF_NS 200
`define SPPC_RXCLK_HALF_CYC ((`SPPC_RXCLK_HALF_NS + `SPPC_CLK_PERIOD_NS - 1) / `SPPC_CLK_PERIOD_NS)

`endif

/* logic/sppc_pkg.sv */
`include "sppc_cfg.svh"
package sppc_pkg;
   typedef enum logic [1:0] {PA_WAIT, PA_ADJUST, PA_LOCKED, PA_BYPASS} sppc_pa_state_e;
   typedef logic [`SPPC_CHAR_W-1:0] sppc_char_t;
   typedef logic [1:0] sppc_level_t;
endpackage

/* logic/sppc_fifo.sv */
`include "sppc_cfg.svh"
module sppc_fifo #(
   parameter int unsigned WIDTH = `SPPC_CHAR_W,
   parameter int unsigned DEPTH = `SPPC_FIFO_DEPTH
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wrPtrQ, wrPtrD, rdPtrQ, rdPtrD;
   logic full, empty, push, pop;

   assign full = (wrPtrQ[AW] != rdPtrQ[AW]) && (wrPtrQ[AW-1:0] == rdPtrQ[AW-1:0]);
   assign empty = (wrPtrQ == rdPtrQ);
   assign inReady = !full;
   assign outValid = !empty;
   assign outData = mem[rdPtrQ[AW-1:0]];
   assign push = inValid && !full;
   assign pop = outReady && !empty;

   always_comb begin
      wrPtrD = push ? wrPtrQ + {{AW{1'b0}}, 1'b1} : wrPtrQ;
      rdPtrD = pop ? rdPtrQ + {{AW{1'b0}}, 1'b1} : rdPtrQ;
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         wrPtrQ <= '0;
         rdPtrQ <= '0;
      end else begin
         wrPtrQ <= wrPtrD;
         rdPtrQ <= rdPtrD;
      end
   end

   // storage carries no reset: contents are only read behind a valid pointer
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wrPtrQ[AW-1:0]] <= inData;
      end
   end

   fifo_full_c: cover property (@(posedge ref_clk) disable iff (!reset_n) full && inValid);
endmodule

/* logic/sppc_rx_lane.sv */
`include "sppc_cfg.svh"
module sppc_rx_lane (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic load,
   input wire sppc_pkg::sppc_char_t inChar,
   input wire sppc_pkg::sppc_level_t frameSel,
   input wire sppc_pkg::sppc_level_t parityCtl,
   output sppc_pkg::sppc_char_t rxChar,
   output logic frameFlag,
   output logic parityBit,
   output logic parityOe
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   sppc_pkg::sppc_char_t charQ, charD;
   logic flagQ, flagD, parQ, parD, isFrame;

   always_comb begin
      isFrame = 1'b0;
      case (frameSel)
         `SPPC_LVL_MID: begin
            isFrame = (inChar[9:3] == `SPPC_COMMA_NEG) || (inChar[9:3] == `SPPC_COMMA_POS);
         end
         `SPPC_LVL_HIGH: begin
            isFrame = (inChar == `SPPC_K285_NEG) || (inChar == `SPPC_K285_POS);
         end
         default: begin
            isFrame = 1'b0;
         end
      endcase
      charD = charQ;
      flagD = flagQ;
      parD = parQ;
      if (load) begin
         charD = inChar;
         flagD = isFrame;
         parD = ~^inChar;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         charQ <= '0;
         flagQ <= 1'b0;
         parQ <= 1'b1;
      end else begin
         charQ <= charD;
         flagQ <= flagD;
         parQ <= parD;
      end
   end

   assign rxChar = charQ;
   assign frameFlag = flagQ;
   assign parityBit = parQ;
   // the pad itself floats; the enable is what the pin driver needs
   assign parityOe = (parityCtl != `SPPC_LVL_LOW);

   parity_odd_a: assert property (parityOe |-> (^{charQ, parQ}) == 1'b1)
      else $error("parity bit does not make an odd count");
   parity_off_a: assert property ((parityCtl == `SPPC_LVL_LOW) |-> !parityOe)
      else $error("parity driver enabled while parity is off");
   k285_flag_a: assert property ((load && frameSel == `SPPC_LVL_HIGH &&
      inChar == `SPPC_K285_POS) |=> (frameFlag && rxChar == `SPPC_K285_POS))
      else $error("k28.5 loaded without framing flag");
   comma_flag_a: assert property ((load && frameSel == `SPPC_LVL_MID &&
      inChar[9:3] != `SPPC_COMMA_NEG && inChar[9:3] != `SPPC_COMMA_POS) |=> !frameFlag)
      else $error("framing flag on a non-comma character");
   frame_seen_c: cover property (load && isFrame);
endmodule

/* verification/sppc_host_model.sv */
module sppc_host_model #(
   parameter int LOCK_WAIT_CYC = 16
) (
   input wire logic ref_clk,
   output logic reference_clock_in,
   output logic [3:0] tx_input_clock_ch,
   output logic tx_phase_align_reset_n
);
   timeunit 1ns;
   timeprecision 1ps;

   // high time is adjustable to provoke duty faults; the period stays 400 ns
   int highNs = 200;

   // reference runs free, phase unrelated to ref_clk
   initial begin
      reference_clock_in = 1'b0;
      tx_phase_align_reset_n = 1'b1;
      #237;
      forever begin
         reference_clock_in = 1'b1;
         #(highNs);
         reference_clock_in = 1'b0;
         #(400 - highNs);
      end
   end

   // tx clocks are frequency-coherent to the reference but offset in phase
   for (genvar i = 0; i < 4; i++) begin : g_txclk
      initial begin
         tx_input_clock_ch[i] = 1'b0;
         #(90 + 70 * i);
         forever #200 tx_input_clock_ch[i] = ~tx_input_clock_ch[i];
      end
   end

   // starts two cycles after a reference rise so short pulses meet one rise only
   task automatic lowPulse(input int cycles);
      @(posedge reference_clock_in);
      repeat (2) @(posedge ref_clk);
      tx_phase_align_reset_n <= 1'b0;
      repeat (cycles) @(posedge ref_clk);
      tx_phase_align_reset_n <= 1'b1;
   endtask

   task automatic initAlign();
      repeat (LOCK_WAIT_CYC) @(posedge ref_clk);
      lowPulse(20);
   endtask
endmodule

/* verification/testbench.sv */
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [3:0] wb_adr_i = 4'h0;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, reference_clock_in, tx_phase_align_reset_n, txAlignBusy, rx_interface_clock;
   logic [3:0] tx_input_clock_ch, deserReady, framing_char_flag, rx_odd_parity_out;
   logic [3:0] rxOddParityOe;
   logic [3:0][9:0] deserChar = '0;
   logic [3:0] deserValid = 4'h0;
   logic [3:0][9:0] rx_char_out;
   logic [3:0] lastPar;
   wire [3:0] parityPin;
   int checks = 0;
   int badCount = 0;
   int cycles = 0;

   always #25 ref_clk = ~ref_clk;
   for (genvar i = 0; i < 4; i++) begin : g_pin
      assign parityPin[i] = rxOddParityOe[i] ? rx_odd_parity_out[i] : 1'bz;
   end

   sppc_port_ctl u_sppc_port_ctl (.ref_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .reference_clock_in,
      .tx_phase_align_reset_n, .tx_input_clock_ch, .txAlignBusy, .deserChar, .deserValid,
      .deserReady, .rx_interface_clock, .rx_char_out, .framing_char_flag,
      .rx_odd_parity_out, .rxOddParityOe);
   sppc_host_model u_sppc_host_model (.ref_clk, .reference_clock_in, .tx_input_clock_ch,
      .tx_phase_align_reset_n);

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         badCount++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic finalReport();
      $display("checks %0d mismatches %0d", checks, badCount);
      if (badCount == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 6000) begin
         badCount++;
         $display("CHECK FAILED run length expected done seen hang");
         finalReport();
      end
   end

   task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] wd,
                     input logic [3:0] sel, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge ref_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= wd;
      wb_sel_i <= sel;
      do begin
         @(posedge ref_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      rd = wb_dat_o;
      check("wb ack", wb_ack_o, 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] x;
      wb(1'b1, a, d, 4'hf, x);
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      wb(1'b0, a, 32'h0, 4'hf, d);
   endtask

   function automatic logic isFrame(input logic [1:0] fs, input logic [9:0] c);
      if (fs == 2'h1) return c[9:3] == 7'h1f || c[9:3] == 7'h60;
      if (fs == 2'h2) return c == 10'h0fa || c == 10'h305;
      return 1'b0;
   endfunction

   task automatic resetCase();
      check("busy", txAlignBusy, 1'b0);
      check("ready", deserReady, 4'hf);
      check("char", rx_char_out[0], 10'h0);
      check("parity", rx_odd_parity_out, 4'hf);
      check("parity oe", rxOddParityOe, 4'hf);
      reset_n <= 1'b1;
   endtask

   task automatic regCase();
      logic [31:0] d;
      rd(4'h0, d);
      check("ctrl reset", d, 32'h25);
      wr(4'h0, 32'hffff_ff45);
      rd(4'h0, d);
      check("ctrl rw", d, 32'h45);
      wb(1'b1, 4'h0, 32'h23, 4'he, d);
      rd(4'h0, d);
      check("ctrl sel", d, 32'h45);
      rd(4'hc, d);
      check("unmapped", d, 32'h0);
      wr(4'h0, 32'h55);
      rd(4'h4, d);
      check("invalid mode", d[3], 1'b1);
      check("pll mult invalid", d[9:5], 5'h14);
   endtask

   task automatic alignCase(input logic [6:0] ctrl, input int len, input logic expBusy,
                            input logic [4:0] mult, input logic byp);
      logic [31:0] s, p1, p2;
      logic seen;
      wr(4'h0, {25'h0, ctrl});
      repeat (20) @(posedge ref_clk);
      seen = 1'b0;
      fork
         u_sppc_host_model.lowPulse(len);
         repeat (len + 40) begin
            @(posedge ref_clk);
            if (txAlignBusy === 1'b1) seen = 1'b1;
         end
      join
      check("busy seen", seen, expBusy);
      check("busy end", txAlignBusy, 1'b0);
      rd(4'h4, s);
      check("pll mult", s[9:5], mult);
      check("bypass", s[2], byp);
      if (expBusy) begin
         check("locked", s[1], 1'b1);
         rd(4'h8, p1);
         repeat (30) @(posedge ref_clk);
         rd(4'h8, p2);
         check("phase frozen", p2, p1);
      end
   endtask

   // runs in half-rate mode: a lopsided reference sets the fault, a reset pulse clears it
   task automatic faultCase();
      logic [31:0] s;
      u_sppc_host_model.highNs = 300;
      repeat (40) @(posedge ref_clk);
      u_sppc_host_model.highNs = 200;
      repeat (20) @(posedge ref_clk);
      rd(4'h4, s);
      check("fault set", s[4], 1'b1);
      u_sppc_host_model.lowPulse(8);
      repeat (30) @(posedge ref_clk);
      rd(4'h4, s);
      check("fault cleared", s[4], 1'b0);
   endtask

   task automatic rxCase(input logic [1:0] fs, input logic [9:0] c);
      logic [3:0][9:0] v;
      int n;
      v = {10'h003, 10'h001, ~c, c};
      wr(4'h0, {25'h0, fs, 5'h05});
      @(posedge ref_clk);
      deserValid <= 4'hf;
      deserChar <= v;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (deserReady !== 4'hf && n < 20);
      deserValid <= 4'h0;
      n = 0;
      while (rx_char_out[0] !== c && n < 40) begin
         @(posedge ref_clk);
         n++;
      end
      check("rx clock high", rx_interface_clock, 1'b1);
      for (int i = 0; i < 4; i++) begin
         lastPar[i] = ~^v[i];
         check("rx char", rx_char_out[i], v[i]);
         check("frame flag", framing_char_flag[i], isFrame(fs, v[i]));
         check("parity", rx_odd_parity_out[i], ~^v[i]);
      end
   endtask

   task automatic parityCase();
      for (int p = 0; p < 4; p++) begin
         wr(4'h0, {25'h0, 2'h2, 1'b0, 2'h1, p[1:0]});
         @(posedge ref_clk);
         check("parity oe", rxOddParityOe, (p != 0) ? 4'hf : 4'h0);
         check("parity pin", parityPin, (p != 0) ? lastPar : 4'bzzzz);
      end
   endtask

   task automatic fifoCase();
      logic [9:0] q[$];
      logic [9:0] v;
      logic [31:0] s;
      logic refused;
      int n;
      v = 10'h010;
      refused = 1'b0;
      n = 0;
      @(posedge ref_clk);
      deserValid <= 4'hf;
      deserChar <= {4{v}};
      while (!refused && n < 200) begin
         @(posedge ref_clk);
         n++;
         if (deserReady === 4'hf) begin
            q.push_back(v);
            v++;
            deserChar <= {4{v}};
         end else begin
            refused = 1'b1;
         end
      end
      deserValid <= 4'h0;
      check("fifo refused", refused, 1'b1);
      check("fifo depth", q.size() >= 8, 1'b1);
      while (q.size() > 0) begin
         v = q.pop_front();
         n = 0;
         while (rx_char_out[0] !== v && n < 20) begin
            @(posedge ref_clk);
            n++;
         end
         check("drain order", rx_char_out[0], v);
      end
      rd(4'h4, s);
      check("fifo empty", s[13:10], 4'h0);
   endtask

   logic [1:0] fsTab [6] = '{2'h2, 2'h1, 2'h2, 2'h1, 2'h0, 2'h3};
   logic [9:0] chTab [6] = '{10'h0fa, 10'h0fc, 10'h0fd, 10'h300, 10'h0fa, 10'h305};

   initial begin
      repeat (2) @(posedge ref_clk);
      resetCase();
      u_sppc_host_model.initAlign();
      regCase();
      alignCase(7'h45, 20, 1'b1, 5'h0a, 1'b0);
      alignCase(7'h45, 8, 1'b0, 5'h0a, 1'b0);
      alignCase(7'h41, 20, 1'b0, 5'h0a, 1'b1);
      alignCase(7'h51, 8, 1'b1, 5'h14, 1'b0);
      faultCase();
      for (int k = 0; k < 6; k++) begin
         rxCase(fsTab[k], chTab[k]);
      end
      parityCase();
      fifoCase();
      finalReport();
   end
endmodule
